// ==== hdl/aipd_pkg.sv ====
// constants, types and decode helpers of the analog input diagnostics
// Operation
// - one writable function byte per channel, default 10h, record sets 80h/81h
// - function FFh switches the channel off, no more results
// - function 10h scales D = 27648*U/10V, limits 32511 and -4864
// - function 20h scales D = 16384*U/10V, limits 20480 and -3277
// - any channel error lights the channel LED and enters the diagnostic record
// - no diagnostic interrupt; diagnostics are only polled
// - detect parameter error, range overflow and range underflow
// - record set 01h reads the whole record, 00h the first 4 bytes
// - object 2F01h reads the whole record, 2F00h the first four bytes
// - summary byte: bit0 failure, bit1 internal, bit2 external, bit3 channel; bits 1-0 stay zero here
// - summary bit4 aux supply missing, bit7 parameter error, bits 6-5 zero
// - module info byte reads 15h: class 0101b plus channel info bit
// - fixed descriptor bytes 71h, 08h and 02h
// - one error byte per channel, then six reserved zero bytes
// - function bytes at object 3100h+slot sub 01h/02h, or 3100h/3101h
// - object 5005h reaches record bytes, subindex 02h is the summary
// - channel error byte: bit0 parameter, bit6 underflow, bit7 overflow
// - group error byte: bit0 group 0 error, bit1 group 1 error
// - time stamp captures the microsecond ticker at each diagnostic event
// - microsecond ticker starts at zero, counts each microsecond, wraps
package aipd_pkg;
  localparam logic [7:0]  FN_DEF   = 8'h10;
  localparam logic [7:0]  FN_NOM   = 8'h10;
  localparam logic [7:0]  FN_ALT   = 8'h20;
  localparam logic [7:0]  FN_OFF   = 8'hff;
  localparam logic [7:0]  RS_FN0   = 8'h80;
  localparam logic [7:0]  RS_FN1   = 8'h81;
  localparam logic [7:0]  RS_HEAD  = 8'h00;
  localparam logic [7:0]  RS_FULL  = 8'h01;
  localparam logic [15:0] IX_HEAD  = 16'h2f00;
  localparam logic [15:0] IX_FULL  = 16'h2f01;
  localparam logic [15:0] IX_FN    = 16'h3100;
  localparam logic [15:0] IX_FN1   = 16'h3101;
  localparam logic [15:0] IX_DIAG  = 16'h5005;
  localparam logic [7:0]  SX_FN0   = 8'h01;
  localparam logic [7:0]  SX_FN1   = 8'h02;
  localparam logic [7:0]  SX_FIRST = 8'h02;
  localparam logic [7:0]  SX_LAST  = 8'h11;
  localparam logic [7:0]  SX_TICK  = 8'h13;
  localparam logic [7:0]  SX_TEND  = 8'h16;
  localparam logic [4:0]  HEAD_LEN = 5'h04;
  localparam logic [4:0]  REC_LEN  = 5'h14;
  // record byte positions
  localparam logic [4:0]  B_SUM  = 5'h00;
  localparam logic [4:0]  B_INFO = 5'h01;
  localparam logic [4:0]  B_TYPE = 5'h04;
  localparam logic [4:0]  B_NBIT = 5'h05;
  localparam logic [4:0]  B_NCH  = 5'h06;
  localparam logic [4:0]  B_GRP  = 5'h07;
  localparam logic [4:0]  B_CH0  = 5'h08;
  localparam logic [4:0]  B_CH1  = 5'h09;
  localparam logic [4:0]  B_TICK = 5'h10;
  // fixed byte values
  localparam logic [7:0]  INFO_VAL = 8'h15;
  localparam logic [7:0]  TYPE_VAL = 8'h71;
  localparam logic [7:0]  NBIT_VAL = 8'h08;
  localparam logic [7:0]  NCH_VAL  = 8'h02;
  localparam logic [7:0]  ZERO_B   = 8'h00;
  // bit positions
  localparam int SUM_EXT  = 2;
  localparam int SUM_CHAN = 3;
  localparam int SUM_AUX  = 4;
  localparam int SUM_PARM = 7;
  localparam int CE_PARM  = 0;
  localparam int CE_UNDER = 6;
  localparam int CE_OVER  = 7;
  // scaling: gain in 1/65536 per millivolt
  localparam logic [17:0] K_NOM   = 18'h2c3ca;
  localparam logic [17:0] K_ALT   = 18'h1a36e;
  localparam int          K_SHIFT = 16;
  localparam logic signed [18:0] NOM_MAX = 19'sh07eff;
  localparam logic signed [18:0] NOM_MIN = -19'sh01300;
  localparam logic signed [18:0] ALT_MAX = 19'sh05000;
  localparam logic signed [18:0] ALT_MIN = -19'sh00ccd;
  // timing
  localparam int CLK_NS = 100;
  localparam int US_NS  = 1000;
  localparam logic [3:0] US_CYC = 4'((US_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {ACC_NONE, ACC_FN0, ACC_FN1, ACC_DIAG} aipd_acc_t;
  typedef struct packed {
    aipd_acc_t  kind;
    logic [4:0] idx;
  } aipd_tgt_t;

  function automatic logic aipd_fn_known(input logic [7:0] fn);
    return (fn == FN_NOM) || (fn == FN_ALT) || (fn == FN_OFF);
  endfunction
endpackage

// ==== hdl/aipd_scale.sv ====
// per-channel value scaling and range check
`timescale 1ns/10ps
module aipd_scale (
  input  wire logic   i_clk_sys,
  input  wire logic   i_rst_b,
  aipd_smp_if.scl     smp
);
  import aipd_pkg::*;

  logic signed [34:0] prod;
  logic signed [18:0] d, hi, lo;
  logic signed [15:0] val, next_val;
  logic               vld, ovf, unf, perr;
  logic               next_vld, next_ovf, next_unf, next_perr;

  // scale and clamp; the value only moves on a sample strobe, off or unknown functions clear the range flags at once
  always_comb begin
    prod = smp.mv * $signed({1'b0, (smp.fn == FN_ALT) ? K_ALT : K_NOM});
    d    = prod[34:K_SHIFT];
    hi   = (smp.fn == FN_ALT) ? ALT_MAX : NOM_MAX;
    lo   = (smp.fn == FN_ALT) ? ALT_MIN : NOM_MIN;
    next_val  = val;
    next_vld  = 1'b0;
    next_ovf  = ovf;
    next_unf  = unf;
    next_perr = !aipd_fn_known(smp.fn);
    if (smp.fn == FN_OFF) begin
      next_ovf = 1'b0;
      next_unf = 1'b0;
    end else if (next_perr) begin
      next_ovf = 1'b0;
      next_unf = 1'b0;
    end else if (smp.stb) begin
      next_vld = 1'b1;
      next_ovf = d > hi;
      next_unf = d < lo;
      if (d > hi)
        next_val = hi[15:0];
      else if (d < lo)
        next_val = lo[15:0];
      else
        next_val = d[15:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      val  <= 16'sh0000;
      vld  <= 1'b0;
      ovf  <= 1'b0;
      unf  <= 1'b0;
      perr <= 1'b0;
    end else begin
      val  <= next_val;
      vld  <= next_vld;
      ovf  <= next_ovf;
      unf  <= next_unf;
      perr <= next_perr;
    end
  end

  assign smp.val  = val;
  assign smp.vld  = vld;
  assign smp.ovf  = ovf;
  assign smp.unf  = unf;
  assign smp.perr = perr;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  chk_nom_limit: assert property (
    (smp.stb && smp.fn == FN_NOM) |=> vld && val <= 16'sh7eff
      && val >= -16'sh1300)
    else $error("nominal scaling outside its limits");
  chk_alt_limit: assert property (
    (smp.stb && smp.fn == FN_ALT) |=> vld && val <= 16'sh5000
      && val >= -16'sh0ccd)
    else $error("alternate scaling outside its limits");
endmodule

// ==== hdl/aipd_smp_if.sv ====
// sample path between channel sequencing and the scaler
`timescale 1ns/10ps
interface aipd_smp_if;
  logic signed [15:0] mv;
  logic               stb;
  logic [7:0]         fn;
  logic signed [15:0] val;
  logic               vld;
  logic               ovf;
  logic               unf;
  logic               perr;
  modport src (output mv, stb, fn, input val, vld, ovf, unf, perr);
  modport scl (input mv, stb, fn, output val, vld, ovf, unf, perr);
endinterface

// ==== hdl/aipd_top.sv ====
// analog input parameter bytes, scaling and diagnostic record
`timescale 1ns/10ps
module aipd_top (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst_b,
  input  wire logic signed [15:0]  i_ain0_mv,
  input  wire logic signed [15:0]  i_ain1_mv,
  input  wire logic [1:0]          i_ain_stb,
  input  wire logic                i_aux_missing,
  input  wire logic [7:0]          i_slot,
  input  wire logic                i_acc_req,
  input  wire logic                i_acc_wr,
  input  wire logic                i_acc_obj,
  input  wire logic                i_acc_ecat,
  input  wire logic [7:0]          i_record_set_number,
  input  wire logic [15:0]         i_object_index,
  input  wire logic [7:0]          i_object_subindex,
  input  wire logic [4:0]          i_acc_byte,
  input  wire logic [7:0]          i_acc_wdata,
  output      logic                o_acc_ack,
  output      logic                o_acc_err,
  output      logic [7:0]          o_acc_rdata,
  output      logic signed [15:0]  o_ain0_value,
  output      logic signed [15:0]  o_ain1_value,
  output      logic [1:0]          o_value_vld,
  output      logic [1:0]          o_chan_led
);
  import aipd_pkg::*;

  logic [7:0]         chan_function_select [2];
  logic [7:0]         next_fn [2];
  logic signed [15:0] smp_val [2];
  logic [1:0]         smp_vld, smp_ovf, smp_unf, smp_perr;
  logic [7:0]         chan_err [2];
  logic [1:0]         flags_q, next_flags_q;
  logic [7:0]         channel_group_errors, module_diag_summary;
  logic               aux_m, aux_s, aux_q, next_aux_q;
  logic [3:0]         us_cnt, next_us_cnt;
  logic [31:0]        ticker, next_ticker;
  logic [31:0]        diag_time_stamp, next_stamp;
  logic               diag_event;
  logic               next_ack, next_err;
  logic [7:0]         next_rdata, diag_byte;
  logic [1:0]         next_led;
  aipd_tgt_t          tgt;

  // map a record set or object address onto a target byte
  function automatic aipd_tgt_t decode(
    input logic        obj,
    input logic        ecat,
    input logic [7:0]  set,
    input logic [15:0] ix,
    input logic [7:0]  sx,
    input logic [7:0]  slot,
    input logic [4:0]  bidx
  );
    aipd_tgt_t t;
    t.kind = ACC_NONE;
    t.idx  = bidx;
    if (!obj) begin
      if (set == RS_FN0)
        t.kind = ACC_FN0;
      else if (set == RS_FN1)
        t.kind = ACC_FN1;
      else if (set == RS_HEAD && bidx < HEAD_LEN)
        t.kind = ACC_DIAG;
      else if (set == RS_FULL && bidx < REC_LEN)
        t.kind = ACC_DIAG;
    end else if (ecat) begin
      if (ix == IX_FN + {8'h00, slot} && sx == SX_FN0)
        t.kind = ACC_FN0;
      else if (ix == IX_FN + {8'h00, slot} && sx == SX_FN1)
        t.kind = ACC_FN1;
      else if (ix == IX_DIAG && sx >= SX_FIRST && sx <= SX_LAST) begin
        t.kind = ACC_DIAG;
        t.idx  = 5'(sx - SX_FIRST);
      end else if (ix == IX_DIAG && sx >= SX_TICK && sx <= SX_TEND) begin
        t.kind = ACC_DIAG;
        t.idx  = 5'(sx - SX_TICK) + B_TICK;
      end
    end else begin
      if (ix == IX_FN)
        t.kind = ACC_FN0;
      else if (ix == IX_FN1)
        t.kind = ACC_FN1;
      else if (ix == IX_HEAD && bidx < HEAD_LEN)
        t.kind = ACC_DIAG;
      else if (ix == IX_FULL && bidx < REC_LEN)
        t.kind = ACC_DIAG;
    end
    return t;
  endfunction

  // one scaler per channel, fed over the sample interface
  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      aipd_smp_if u_smp ();
      assign u_smp.mv  = (c == 0) ? i_ain0_mv : i_ain1_mv;
      assign u_smp.stb = i_ain_stb[c];
      assign u_smp.fn  = chan_function_select[c];
      assign smp_val[c]  = u_smp.val;
      assign smp_vld[c]  = u_smp.vld;
      assign smp_ovf[c]  = u_smp.ovf;
      assign smp_unf[c]  = u_smp.unf;
      assign smp_perr[c] = u_smp.perr;
      aipd_scale u_scale (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .smp       (u_smp.scl)
      );
    end
  endgenerate

  // channel error bytes and group bits in one process, so each of them
  // has a single driver; reserved bits of both stay zero
  always_comb begin
    channel_group_errors = ZERO_B;
    for (int c = 0; c < 2; c++) begin
      chan_err[c]             = ZERO_B;
      chan_err[c][CE_PARM]    = smp_perr[c];
      chan_err[c][CE_UNDER]   = smp_unf[c];
      chan_err[c][CE_OVER]    = smp_ovf[c];
      channel_group_errors[c] = |chan_err[c];
    end
  end

  assign o_ain0_value = smp_val[0];
  assign o_ain1_value = smp_val[1];
  assign o_value_vld  = smp_vld;

  // summary byte; failure and internal bits have no source here
  always_comb begin
    module_diag_summary           = ZERO_B;
    module_diag_summary[SUM_EXT]  = aux_s;
    module_diag_summary[SUM_AUX]  = aux_s;
    module_diag_summary[SUM_CHAN] = |channel_group_errors;
    module_diag_summary[SUM_PARM] = |smp_perr;
  end

  // microsecond ticker and time stamp of each new diagnostic event
  always_comb begin
    next_us_cnt = us_cnt + 4'h1;
    next_ticker = ticker;
    if (us_cnt == US_CYC - 4'h1) begin
      next_us_cnt = 4'h0;
      next_ticker = ticker + 32'h1;
    end
    next_flags_q = channel_group_errors[1:0];
    next_aux_q   = aux_s;
    // only rising errors count, so a standing fault keeps its first stamp
    diag_event = |(channel_group_errors[1:0] & ~flags_q) | (aux_s & ~aux_q);
    next_stamp = diag_event ? ticker : diag_time_stamp;
    for (int c = 0; c < 2; c++)
      next_led[c] = |chan_err[c];
  end

  // aux supply flag comes from a pin and passes two flops first
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      aux_m           <= 1'b0;
      aux_s           <= 1'b0;
      aux_q           <= 1'b0;
      flags_q         <= 2'h0;
      us_cnt          <= 4'h0;
      ticker          <= 32'h0;
      diag_time_stamp <= 32'h0;
      o_chan_led      <= 2'h0;
    end else begin
      aux_m           <= i_aux_missing;
      aux_s           <= aux_m;
      aux_q           <= next_aux_q;
      flags_q         <= next_flags_q;
      us_cnt          <= next_us_cnt;
      ticker          <= next_ticker;
      diag_time_stamp <= next_stamp;
      o_chan_led      <= next_led;
    end
  end

  // record byte selection; reserved and unused channel bytes read zero
  always_comb begin
    case (tgt.idx)
      B_SUM:           diag_byte = module_diag_summary;
      B_INFO:          diag_byte = INFO_VAL;
      B_TYPE:          diag_byte = TYPE_VAL;
      B_NBIT:          diag_byte = NBIT_VAL;
      B_NCH:           diag_byte = NCH_VAL;
      B_GRP:           diag_byte = channel_group_errors;
      B_CH0:           diag_byte = chan_err[0];
      B_CH1:           diag_byte = chan_err[1];
      B_TICK:          diag_byte = diag_time_stamp[7:0];
      B_TICK + 5'h01:  diag_byte = diag_time_stamp[15:8];
      B_TICK + 5'h02:  diag_byte = diag_time_stamp[23:16];
      B_TICK + 5'h03:  diag_byte = diag_time_stamp[31:24];
      default:         diag_byte = ZERO_B;
    endcase
  end

  // access handling: one answer per request, the cycle after it
  always_comb begin
    tgt = decode(i_acc_obj, i_acc_ecat, i_record_set_number,
                 i_object_index, i_object_subindex, i_slot, i_acc_byte);
    next_fn    = chan_function_select;
    next_ack   = i_acc_req;
    next_err   = 1'b0;
    next_rdata = ZERO_B;
    if (i_acc_req) begin
      case (tgt.kind)
        ACC_FN0, ACC_FN1: begin
          if (i_acc_wr)
            next_fn[tgt.kind == ACC_FN1] = i_acc_wdata;
          else
            next_rdata = chan_function_select[tgt.kind == ACC_FN1];
        end
        ACC_DIAG: begin
          // the record is polled only, never pushed
          next_err   = i_acc_wr;
          next_rdata = i_acc_wr ? ZERO_B : diag_byte;
        end
        default: next_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      chan_function_select[0] <= FN_DEF;
      chan_function_select[1] <= FN_DEF;
      o_acc_ack               <= 1'b0;
      o_acc_err               <= 1'b0;
      o_acc_rdata             <= ZERO_B;
    end else begin
      chan_function_select    <= next_fn;
      o_acc_ack               <= next_ack;
      o_acc_err               <= next_err;
      o_acc_rdata             <= next_rdata;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_fn0_write;
    i_acc_req && i_acc_wr && !i_acc_obj && i_record_set_number == RS_FN0;
  endsequence
  sequence s_head_over;
    i_acc_req && !i_acc_obj && i_record_set_number == RS_HEAD
      && i_acc_byte >= HEAD_LEN;
  endsequence

  sequence s_fn1_obj_write;
    i_acc_req && i_acc_wr && i_acc_obj && !i_acc_ecat
      && i_object_index == IX_FN1;
  endsequence

  chk_fn_default: assert property (
    $rose(i_rst_b) |-> chan_function_select[0] == FN_DEF
      && chan_function_select[1] == FN_DEF)
    else $error("function byte not at default after reset");
  chk_fn_write: assert property (
    s_fn0_write |=> o_acc_ack && chan_function_select[0] == $past(i_acc_wdata))
    else $error("function byte write lost");
  chk_off_quiet: assert property (
    (chan_function_select[1] == FN_OFF) [*2] |-> !o_value_vld[1])
    else $error("switched-off channel produced a value");
  chk_led_error: assert property (
    (|chan_err[1]) |=> o_chan_led[1])
    else $error("channel LED not lit on error");
  chk_sum_chan: assert property (
    module_diag_summary[SUM_CHAN] == (|channel_group_errors[1:0]))
    else $error("summary channel bit disagrees with group byte");
  chk_head_limit: assert property (
    s_head_over |=> o_acc_ack && o_acc_err)
    else $error("head record read past four bytes accepted");
  chk_tick_step: assert property (
    us_cnt == US_CYC - 4'h1 |=> ticker == $past(ticker) + 32'h1
      ##1 ticker == $past(ticker))
    else $error("microsecond ticker stepped wrongly");
  chk_stamp_take: assert property (
    diag_event |=> diag_time_stamp == $past(ticker))
    else $error("time stamp not captured at diagnostic event");
  chk_perr_flag: assert property (
    !aipd_fn_known(chan_function_select[0]) |=> chan_err[0][CE_PARM])
    else $error("parameter error not flagged");
  // the access port answers each request exactly once, a cycle later
  chk_ack_pulse: assert property (
    o_acc_ack == $past(i_acc_req))
    else $error("access answer not one cycle after request");
  chk_refuse_zero: assert property (
    o_acc_err |-> o_acc_ack && o_acc_rdata == ZERO_B)
    else $error("refused access returned data");
  chk_fn1_write: assert property (
    s_fn1_obj_write |=> chan_function_select[1] == $past(i_acc_wdata))
    else $error("function byte write by object lost");
  chk_led_off: assert property (
    !(|chan_err[0]) |=> !o_chan_led[0])
    else $error("channel LED lit without error");
  chk_stamp_hold: assert property (
    !diag_event |=> diag_time_stamp == $past(diag_time_stamp))
    else $error("time stamp moved without diagnostic event");
  chk_fixed_type: assert property (
    i_acc_req && !i_acc_wr && !i_acc_obj && i_record_set_number == RS_FULL
      && i_acc_byte == B_TYPE |=> o_acc_rdata == TYPE_VAL)
    else $error("channel kind byte misread");
endmodule

// ==== verif/aipd_master.sv ====
// bus master model that reads and writes the parameter and diagnostic bytes
`timescale 1ns/10ps
module aipd_master (
  input  wire logic        i_clk_sys,
  input  wire logic        i_acc_ack,
  input  wire logic        i_acc_err,
  input  wire logic [7:0]  i_acc_rdata,
  output      logic        o_acc_req,
  output      logic        o_acc_wr,
  output      logic        o_acc_obj,
  output      logic        o_acc_ecat,
  output      logic [7:0]  o_record_set_number,
  output      logic [15:0] o_object_index,
  output      logic [7:0]  o_object_subindex,
  output      logic [4:0]  o_acc_byte,
  output      logic [7:0]  o_acc_wdata
);
  // idle bus at time zero
  initial begin
    o_acc_req           = 1'b0;
    o_acc_wr            = 1'b0;
    o_acc_obj           = 1'b0;
    o_acc_ecat          = 1'b0;
    o_record_set_number = 8'h00;
    o_object_index      = 16'h0000;
    o_object_subindex   = 8'h00;
    o_acc_byte          = 5'h00;
    o_acc_wdata         = 8'h00;
  end

  // one byte per access: request is a one-cycle pulse, answer a cycle later
  task automatic acc(input logic w, o, e, input logic [7:0] s,
                     input logic [15:0] ix, input logic [7:0] sx,
                     input logic [4:0] b, input logic [7:0] wd,
                     output logic ok, er, output logic [7:0] rd);
    @(negedge i_clk_sys);
    o_acc_req           = 1'b1;
    o_acc_wr            = w;
    o_acc_obj           = o;
    o_acc_ecat          = e;
    o_record_set_number = s;
    o_object_index      = ix;
    o_object_subindex   = sx;
    o_acc_byte          = b;
    o_acc_wdata         = wd;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    ok = i_acc_ack;
    er = i_acc_err;
    rd = i_acc_rdata;
    // stale write data and byte index are scrambled so nothing can lean on them
    o_acc_req   = 1'b0;
    o_acc_wdata = ~wd;
    o_acc_byte  = ~b;
  endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench of the analog input parameter and diagnostic block
`timescale 1ns/10ps
module tb_top;
  import aipd_pkg::*;
  logic               clk, rst_b, aux, req, wr, obj, ecat, ack, err;
  logic signed [15:0] mv0, mv1, v0, v1;
  logic [1:0]         stb, vld, led;
  logic [7:0]         slot, set, sx, wd, rdata;
  logic [15:0]        ix;
  logic [4:0]         bsel;
  logic [7:0]         fnv [2];
  logic [7:0]         chf [2];
  logic signed [15:0] corner [8];
  int                 fail_count, n_tests, cyc, t_ev;

  aipd_master M (.i_clk_sys(clk), .i_acc_ack(ack), .i_acc_err(err),
    .i_acc_rdata(rdata), .o_acc_req(req), .o_acc_wr(wr), .o_acc_obj(obj),
    .o_acc_ecat(ecat), .o_record_set_number(set), .o_object_index(ix),
    .o_object_subindex(sx), .o_acc_byte(bsel), .o_acc_wdata(wd));

  aipd_top DUT (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ain0_mv(mv0),
    .i_ain1_mv(mv1), .i_ain_stb(stb), .i_aux_missing(aux), .i_slot(slot),
    .i_acc_req(req), .i_acc_wr(wr), .i_acc_obj(obj), .i_acc_ecat(ecat),
    .i_record_set_number(set), .i_object_index(ix),
    .i_object_subindex(sx), .i_acc_byte(bsel), .i_acc_wdata(wd),
    .o_acc_ack(ack), .o_acc_err(err), .o_acc_rdata(rdata),
    .o_ain0_value(v0), .o_ain1_value(v1), .o_value_vld(vld),
    .o_chan_led(led));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // cycle count since reset release; also cuts a hang short
  always @(posedge clk) begin
    if (rst_b) cyc <= cyc + 1;
    if (cyc > 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // expected record byte from the bench's own view of the error state
  function automatic logic [7:0] rec(int i);
    logic [1:0] g;
    g = {chf[1] != 8'h00, chf[0] != 8'h00};
    case (i)
      0: return {chf[0][0] | chf[1][0], 2'b00, aux, |g, aux, 2'b00};
      1: return 8'h15;
      4: return 8'h71;
      5: return 8'h08;
      6: return 8'h02;
      7: return {6'h00, g};
      8: return chf[0];
      9: return chf[1];
      default: return 8'h00;
    endcase
  endfunction

  // scaled value and range flags, floor of the fixed-point product
  function automatic logic signed [15:0] scl(logic signed [15:0] mv,
                                             logic [7:0] f,
                                             output logic [7:0] fl);
    longint d, hi, lo;
    d  = (longint'(mv) * ((f == FN_NOM) ? 181194 : 107374)) >>> 16;
    hi = (f == FN_NOM) ? 32511 : 20480;
    lo = (f == FN_NOM) ? -4864 : -3277;
    fl = (d > hi) ? 8'h80 : (d < lo) ? 8'h40 : 8'h00;
    if (d > hi) d = hi;
    if (d < lo) d = lo;
    return 16'(d);
  endfunction

  task automatic go(input logic w, o, e, input logic [7:0] s,
                    input logic [15:0] x, input logic [7:0] sb,
                    input logic [4:0] b, input logic [7:0] d,
                    input logic xe, input logic [7:0] xr);
    logic ok, er;
    logic [7:0] rd;
    M.acc(w, o, e, s, x, sb, b, d, ok, er, rd);
    chk("ack", 1, ok);
    chk("err", xe, er);
    if (!w) chk("rdata", xr, rd);
  endtask

  // every diagnostic map: full set, object, ethercat, then the short heads
  task automatic recall();
    for (int m = 0; m < 5; m++)
      for (int i = 0; i < ((m < 3) ? 16 : 4); i++)
        go(0, m inside {1, 2, 4}, m == 2, (m == 3) ? RS_HEAD : RS_FULL,
           (m == 4) ? IX_HEAD : (m == 2) ? IX_DIAG : IX_FULL, 8'(i + 2),
           5'(i), 8'h00, 0, rec(i));
  endtask

  // write a function byte through one map, read it back through another
  task automatic wfn(int c, logic [7:0] v, int m);
    for (int k = 0; k < 2; k++) begin
      case ((m + k) % 3)
        0: go(!k, 0, 0, 8'(RS_FN0 + c), 16'h0, 8'h0, 5'h0, v, 0, v);
        1: go(!k, 1, 0, 8'h0, 16'(IX_FN + c), 8'h0, 5'h0, v, 0, v);
        default: go(!k, 1, 1, 8'h0, 16'(IX_FN + slot), 8'(c + 1), 5'h0,
                    v, 0, v);
      endcase
    end
    fnv[c] = v;
    // a new known function keeps range flags until the next sample
    chf[c] = (v == FN_OFF) ? 8'h00 :
             (v == FN_NOM || v == FN_ALT) ? (chf[c] & 8'hc0) : 8'h01;
  endtask

  // one strobed sample, value a cycle later, lamp a cycle after that
  task automatic smp(int c, logic signed [15:0] mv);
    logic [7:0] fl;
    logic signed [15:0] ev;
    ev = scl(mv, fnv[c], fl);
    @(negedge clk);
    stb[c] = 1'b1;
    if (c == 0) mv0 = mv;
    else mv1 = mv;
    @(negedge clk);
    stb = 2'b00;
    if (fnv[c] == FN_OFF) begin
      chk("vld", 0, vld[c]);
      fl = 8'h00;
    end else begin
      chk("vld", 1, vld[c]);
      chk("value", ev, (c == 0) ? v0 : v1);
    end
    if (chf[c] == 8'h00 && fl != 8'h00) t_ev = cyc;
    chf[c] = fl;
    @(negedge clk);
    chk("led", fl != 8'h00, led[c]);
  endtask

  task automatic stamp_check();
    logic ok, er;
    logic [7:0] rd;
    logic [31:0] st;
    int d;
    for (int b = 16; b < 20; b++) begin
      M.acc(0, 0, 0, RS_FULL, 16'h0, 8'h0, 5'(b), 8'h0, ok, er, rd);
      chk("ack", 1, ok);
      st[(b - 16) * 8 +: 8] = rd;
      go(0, 1, 1, 8'h0, IX_DIAG, 8'(b + 3), 5'h0, 8'h0, 0, rd);
    end
    d = int'(st) - t_ev / 10;
    chk("stamp near", 1, d >= -1 && d <= 1);
  endtask

  initial begin
    rst_b = 1'b0;
    aux = 1'b0;
    stb = 2'b00;
    mv0 = 16'sh0000;
    mv1 = 16'sh0000;
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    t_ev = 0;
    fnv = '{8'h10, 8'h10};
    chf = '{8'h00, 8'h00};
    corner = '{16'sd11759, 16'sd11760, -16'sd1759, -16'sd1760,
               16'sd12500, 16'sd12507, -16'sd2000, -16'sd2001};
    void'($urandom(18153));
    slot = 8'($urandom_range(255));
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    go(0, 0, 0, RS_FN0, 16'h0, 8'h0, 5'h0, 8'h0, 0, 8'h10);
    go(0, 0, 0, RS_FN1, 16'h0, 8'h0, 5'h0, 8'h0, 0, 8'h10);
    recall();
    // corners on the range limits first, then random voltages
    for (int r = 0; r < 40; r++) begin
      if (fnv[r % 2] !== (((r / 4) % 2) ? FN_ALT : FN_NOM))
        wfn(r % 2, ((r / 4) % 2) ? FN_ALT : FN_NOM, r % 3);
      smp(r % 2, (r < 8) ? corner[r] :
          16'(int'($urandom_range(19000)) - 6000));
      if (r % 8 == 7) recall();
    end
    smp(0, 16'sd1000);
    smp(1, 16'sd1000);
    smp(0, 16'sd12000);
    stamp_check();
    recall();
    wfn(1, FN_OFF, 0);
    smp(1, 16'sd12000);
    recall();
    wfn(0, 8'h33, 2);
    repeat (2) @(negedge clk);
    chk("led", 1, led[0]);
    recall();
    aux = 1'b1;
    repeat (4) @(negedge clk);
    recall();
    aux = 1'b0;
    repeat (4) @(negedge clk);
    recall();
    // refused places: past the heads, past the record, writes, unmapped
    go(0, 0, 0, RS_HEAD, 16'h0, 8'h0, 5'h04, 8'h0, 1, 8'h00);
    go(0, 0, 0, RS_FULL, 16'h0, 8'h0, 5'h14, 8'h0, 1, 8'h00);
    go(0, 1, 1, 8'h0, IX_DIAG, 8'h12, 5'h0, 8'h0, 1, 8'h00);
    go(0, 1, 0, 8'h0, IX_HEAD, 8'h0, 5'h04, 8'h0, 1, 8'h00);
    go(1, 0, 0, RS_FULL, 16'h0, 8'h0, 5'h00, 8'hff, 1, 8'h00);
    go(0, 0, 0, 8'h02, 16'h0, 8'h0, 5'h00, 8'h0, 1, 8'h00);
    recall();
    test_done();
  end
endmodule
